// ===== rtl/srh_ctrl.sv
/*
  Host-side controller for an asynchronous 1M x 16 static memory with ECC.
  Assumes the memory sits on board pins; data and error come back unsynchronised
  and are sampled through two flip-flops before use.
*/
// Operation
// - Hold write data stable around whichever strobe ends the write.
// - Write-strobe-led write with output enable low lasts float delay plus setup.
// - Never drive data lines while the memory may be driving them.
// - Keep write strobe high throughout every read.
// - Address is valid no later than select falling.
// - Drive all control pins to valid levels even when deselected.
// - Never drive the error pin from outside.
module srh_ctrl
  import srh_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire srh_pkg::srh_req_t req_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  output logic [srh_pkg::DATA_W-1:0] rdata_o,
  output logic rerr_o,
  output logic rvalid_o,
  output srh_pkg::srh_pins_t pins_o,
  output logic [srh_pkg::DATA_W-1:0] dq_out_o,
  output logic [srh_pkg::LANES-1:0] dq_oe_o,
  input wire logic [srh_pkg::DATA_W-1:0] dq_in_i,
  input wire logic err_in_i
);
  import srh_pkg::*;

  typedef struct packed {
    srh_state_t st;
    logic [CNT_W-1:0] cnt;
    srh_pins_t pins;
    logic [DATA_W-1:0] dq_out;
    logic [LANES-1:0] dq_oe;
    logic [DATA_W-1:0] rdata;
    logic rerr;
    logic rvalid;
    logic ready;
    logic [LANES-1:0] lanes;
    logic [DATA_W:0] sync1;
    logic [DATA_W:0] sync2;
  } srh_st_t;

  localparam srh_pins_t PINS_IDLE = '{chip_select_first_n: 1'b1, chip_select_second: 1'b0,
    oe_n: 1'b1, we_n: 1'b1, lower_lane_enable_n: 1'b1, upper_lane_enable_n: 1'b1,
    addr: '0};

  srh_st_t q;
  srh_st_t next_q;
  logic [LANES-1:0] lane_mask;

  // One lane mask bit per byte of returned data
  genvar gi;
  generate
    for (gi = 0; gi < LANES; gi++) begin : g_lane
      assign lane_mask[gi] = q.lanes[gi];
    end
  endgenerate

  always_comb begin
    next_q = q;
    next_q.rvalid = 1'b0;
    // error pin only sampled
    // Synchroniser: second stage reads only the first
    next_q.sync1 = {err_in_i, dq_in_i};
    next_q.sync2 = q.sync1;
    case (q.st)
      ST_IDLE: begin
        next_q.ready = 1'b1;
        if (req_valid_i && q.ready && (req_i.lane_en != '0)) begin
          next_q.ready = 1'b0;
          next_q.lanes = req_i.lane_en;
          next_q.pins.addr = req_i.addr;
          next_q.pins.chip_select_first_n = 1'b0;
          next_q.pins.chip_select_second = 1'b1;
          next_q.pins.lower_lane_enable_n = ~req_i.lane_en[0];
          next_q.pins.upper_lane_enable_n = ~req_i.lane_en[1];
          if (req_i.write) begin
            // output enable off so the memory floats before we drive
            next_q.pins.oe_n = 1'b1;
            next_q.pins.we_n = 1'b0;
            next_q.dq_out = req_i.wdata;
            next_q.dq_oe = req_i.lane_en;
            next_q.cnt = CNT_W'(WRITE_CYC);
            next_q.st = ST_WRITE;
          end else begin
            next_q.pins.we_n = 1'b1;
            next_q.pins.oe_n = 1'b0;
            next_q.dq_oe = '0;
            // Extra cycle: the captured word must have crossed both sync stages after access
            next_q.cnt = CNT_W'(READ_CYC + 1);
            next_q.st = ST_READ;
          end
        end
      end
      ST_WRITE: begin
        if (q.cnt == CNT_W'(1)) begin
          // strobe rises first, data held one more cycle
          next_q.pins.we_n = 1'b1;
          next_q.cnt = CNT_W'(REC_CYC);
          next_q.st = ST_RECOVER;
        end else begin
          next_q.cnt = q.cnt - CNT_W'(1);
        end
      end
      ST_READ: begin
        if (q.cnt == CNT_W'(1)) begin
          next_q.rdata = q.sync2[DATA_W-1:0] &
                         {{LANE_W{lane_mask[1]}}, {LANE_W{lane_mask[0]}}};
          next_q.rerr = q.sync2[DATA_W];
          next_q.rvalid = 1'b1;
          next_q.pins.oe_n = 1'b1;
          next_q.cnt = CNT_W'(REC_CYC);
          next_q.st = ST_RECOVER;
        end else begin
          next_q.cnt = q.cnt - CNT_W'(1);
        end
      end
      ST_RECOVER: begin
        // park pins at valid idle levels
        next_q.pins = PINS_IDLE;
        next_q.pins.addr = q.pins.addr;
        next_q.dq_oe = '0;
        if (q.cnt == CNT_W'(1)) begin
          next_q.st = ST_IDLE;
          next_q.ready = 1'b1;
        end else begin
          next_q.cnt = q.cnt - CNT_W'(1);
        end
      end
      default: begin
        next_q.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '{st: ST_IDLE, cnt: '0, pins: PINS_IDLE, dq_out: '0, dq_oe: '0, rdata: '0,
             rerr: 1'b0, rvalid: 1'b0, ready: 1'b0, lanes: '0, sync1: '0, sync2: '0};
    end else if (clk_en_i) begin
      q <= next_q;
    end
  end

  assign req_ready_o = q.ready;
  assign rdata_o = q.rdata;
  assign rerr_o = q.rerr;
  assign rvalid_o = q.rvalid;
  assign pins_o = q.pins;
  assign dq_out_o = q.dq_out;
  assign dq_oe_o = q.dq_oe;

  AST_READ_WE_HIGH: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (q.st == ST_READ) |-> q.pins.we_n)
    else $error("write strobe low in read");
  AST_NO_DRIVE_OE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (q.dq_oe != '0) |-> q.pins.oe_n)
    else $error("data driven with oe low");
  AST_SELECT_PAIR: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (q.st inside {ST_READ, ST_WRITE}) |-> (!q.pins.chip_select_first_n &&
    q.pins.chip_select_second))
    else $error("select not asserted");
  // four cycles cover float plus setup
  AST_WE_WIDTH: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (clk_en_i && $fell(q.pins.we_n)) |-> !q.pins.we_n [*4])
    else $error("write strobe too short");
  AST_DATA_HOLD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (clk_en_i && $rose(q.pins.we_n)) |-> ($stable(q.dq_out) && $stable(q.dq_oe) &&
    (q.dq_oe != '0)))
    else $error("data changed at write end");
  AST_IDLE_LEVELS: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (q.st == ST_IDLE) |-> (q.pins.we_n && q.pins.oe_n && q.pins.chip_select_first_n &&
    !q.pins.chip_select_second && q.dq_oe == '0))
    else $error("idle pins not parked");
  AST_LANE_DRIVE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (q.st == ST_WRITE) |-> (q.dq_oe == ~{q.pins.upper_lane_enable_n,
    q.pins.lower_lane_enable_n}))
    else $error("lane drive mismatch");
  AST_ADDR_STABLE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (q.st inside {ST_READ, ST_WRITE}) && clk_en_i |=> $stable(q.pins.addr))
    else $error("address moved during access");
  AST_WE_OE_EXCL: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !(!q.pins.we_n && !q.pins.oe_n))
    else $error("write and output strobes both low");
  AST_ADDR_HELD_SEL: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (clk_en_i && !q.pins.chip_select_first_n) |=> $stable(q.pins.addr))
    else $error("address moved while selected");
  // turnaround gap after read; the memory needs time to float its drivers
  AST_TURN_GAP: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(q.pins.oe_n) |-> (q.dq_oe == '0) [*2])
    else $error("data driven too soon after read");
  AST_WDATA_HELD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (clk_en_i && !q.pins.we_n) |=> ($stable(q.dq_out) && $stable(q.dq_oe)))
    else $error("write data moved under strobe");
endmodule // srh_ctrl

// ===== rtl/srh_pkg.sv
/*
  Shared constants and carrier types for the static memory host controller.
  Assumes a 200 MHz core clock and the memory's slower grade timings.
*/
package srh_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;
  localparam int LANES = 2;
  localparam int CLK_PERIOD_NS = 5;
  // Slower speed grade figures, in ns
  localparam int ADDR_TO_DATA_NS = 15;
  localparam int WE_TO_FLOAT_NS = 8;
  localparam int DATA_SETUP_NS = 8;
  localparam int WE_PULSE_NS = 12;
  localparam int CYCLE_NS = 15;
  localparam int TURN_NS = 8;
  // Longest-of and rounded-up cycle counts
  localparam int READ_CYC = (ADDR_TO_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int WP_NS = (WE_PULSE_NS > WE_TO_FLOAT_NS + DATA_SETUP_NS) ?
                         WE_PULSE_NS : WE_TO_FLOAT_NS + DATA_SETUP_NS;
  localparam int WRITE_CYC = (WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REC_CYC = (TURN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  localparam int MIN_CYC_CYC = (CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic write;
    logic [LANES-1:0] lane_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } srh_req_t;

  typedef struct packed {
    logic chip_select_first_n;
    logic chip_select_second;
    logic oe_n;
    logic we_n;
    logic lower_lane_enable_n;
    logic upper_lane_enable_n;
    logic [ADDR_W-1:0] addr;
  } srh_pins_t;

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_RECOVER} srh_state_t;
endpackage

// ===== verif/srh_mem_model.sv
/*
  Behavioural 1M x 16 static memory with single-bit correction, seen at its pins.
  Assumes the bench names one address whose stored word reads back as corrected.
*/
module srh_mem_model
  import srh_pkg::*;
(
  input wire srh_pkg::srh_pins_t pins_i,
  input wire logic [srh_pkg::DATA_W-1:0] dq_host_i,
  input wire logic [srh_pkg::LANES-1:0] dq_oe_i,
  input wire logic [srh_pkg::ADDR_W-1:0] bad_addr_i,
  output logic [srh_pkg::DATA_W-1:0] dq_o,
  output logic err_o
);
  import srh_pkg::*;
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] word;
  logic [LANES-1:0] ln;
  logic [LANES-1:0] dev;
  logic sel;
  logic rd;
  assign sel = !pins_i.chip_select_first_n && pins_i.chip_select_second;
  assign ln = ~{pins_i.upper_lane_enable_n, pins_i.lower_lane_enable_n};
  assign rd = sel && !pins_i.oe_n && pins_i.we_n && (ln != 2'b00);
  // Untouched words read back as zero
  initial begin
    for (int a = 0; a < (1 << ADDR_W); a++) begin
      mem[a] = '0;
    end
  end
  // whole word kept, so a flipped bit is always correctable
  // Decoded straight from the pins so the store never sees a stale select
  always @(pins_i, dq_host_i, dq_oe_i) begin
    for (int i = 0; i < LANES; i++) begin
      if (!pins_i.chip_select_first_n && pins_i.chip_select_second && !pins_i.we_n &&
          !(i == 0 ? pins_i.lower_lane_enable_n : pins_i.upper_lane_enable_n)) begin
        mem[pins_i.addr][i*LANE_W+:LANE_W] =
          dq_oe_i[i] ? dq_host_i[i*LANE_W+:LANE_W] : 8'hxx;
      end
    end
    word = mem[pins_i.addr];
  end
  // float shows inverse pattern; clash on a lane reads unknown
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign dev[i] = rd && ln[i];
    assign dq_o[i*LANE_W+:LANE_W] = (dev[i] && dq_oe_i[i]) ? 8'hxx :
      dev[i] ? word[i*LANE_W+:LANE_W] :
      dq_oe_i[i] ? dq_host_i[i*LANE_W+:LANE_W] : ~word[i*LANE_W+:LANE_W];
  end
  assign err_o = rd ? (pins_i.addr == bad_addr_i) : ~pins_i.addr[0];
endmodule // srh_mem_model

// ===== verif/async_sram_ecc_access_test.sv
/*
  Self-checking bench for the static memory host controller.
  Assumes the controller contract: one request at a time, read answer on rvalid.
*/
module async_sram_ecc_access_test;
  timeunit 1ns;
  timeprecision 100ps;
  import srh_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  srh_req_t req = '0;
  logic req_valid = 1'b0;
  logic clk_en = 1'b1;
  logic ready, rerr, rvalid, err_in;
  logic [DATA_W-1:0] rdata, dq_out, dq_in;
  logic [LANES-1:0] dq_oe;
  srh_pins_t pins;
  logic [ADDR_W-1:0] bad_addr = 20'hfffff;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  always #2.5 core_clk = ~core_clk;
  srh_ctrl i_srh_ctrl (.core_clk_i(core_clk), .rst_n_i(rst_n), .clk_en_i(clk_en), .req_i(req),
    .req_valid_i(req_valid), .req_ready_o(ready), .rdata_o(rdata), .rerr_o(rerr),
    .rvalid_o(rvalid), .pins_o(pins), .dq_out_o(dq_out), .dq_oe_o(dq_oe), .dq_in_i(dq_in),
    .err_in_i(err_in));
  srh_mem_model i_srh_mem_model (.pins_i(pins), .dq_host_i(dq_out), .dq_oe_i(dq_oe),
    .bad_addr_i(bad_addr), .dq_o(dq_in), .err_o(err_in));
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk_word(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_flag(input logic g, input logic e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic issue(input logic w, input logic [1:0] ln, input logic [19:0] a,
                       input logic [15:0] d);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      #1 n++;
    end
    req = '{write: w, lane_en: ln, addr: a, wdata: d};
    req_valid = 1'b1;
    @(posedge core_clk);
    #1 req_valid = 1'b0;
  endtask
  task automatic rd_chk(input logic [1:0] ln, input logic [19:0] a, input logic [15:0] ed,
                        input logic ee);
    int n;
    n = 0;
    issue(1'b0, ln, a, 16'h0000);
    while (rvalid !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk_flag(rvalid, 1'b1);
    chk_word(rdata, ed);
    chk_flag(rerr, ee);
  endtask
  task automatic t_full;
    issue(1'b1, 2'b11, 20'h12345, 16'ha5c3);
    rd_chk(2'b11, 20'h12345, 16'ha5c3, 1'b0);
    $display("t_full done");
  endtask
  task automatic t_lanes;
    issue(1'b1, 2'b01, 20'h12345, 16'hff3c);
    rd_chk(2'b11, 20'h12345, 16'ha53c, 1'b0);
    rd_chk(2'b01, 20'h12345, 16'h003c, 1'b0);
    issue(1'b1, 2'b10, 20'h12345, 16'h77ee);
    rd_chk(2'b10, 20'h12345, 16'h7700, 1'b0);
    $display("t_lanes done");
  endtask
  task automatic t_err;
    issue(1'b1, 2'b11, 20'hfffff, 16'h0f0f);
    rd_chk(2'b11, 20'hfffff, 16'h0f0f, 1'b1);
    rd_chk(2'b11, 20'h12345, 16'h773c, 1'b0);
    $display("t_err done");
  endtask
  task automatic t_freeze;
    int n;
    n = 0;
    issue(1'b1, 2'b00, 20'h12345, 16'hdead);
    chk_flag(ready, 1'b1);
    @(posedge core_clk);
    #1 issue(1'b0, 2'b11, 20'h12345, 16'h0000);
    clk_en = 1'b0;
    repeat (8) @(posedge core_clk);
    #1 chk_flag(rvalid, 1'b0);
    chk_flag(pins.we_n, 1'b1);
    clk_en = 1'b1;
    while (rvalid !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk_flag(rvalid, 1'b1);
    chk_word(rdata, 16'h773c);
    $display("t_freeze done");
  endtask
  task automatic t_reset;
    issue(1'b1, 2'b11, 20'h00abc, 16'h1234);
    @(posedge core_clk);
    #1 rst_n = 1'b0;
    @(posedge core_clk);
    #1 chk_flag(pins.we_n, 1'b1);
    chk_flag(pins.chip_select_first_n, 1'b1);
    chk_flag(pins.chip_select_second, 1'b0);
    chk_flag(|dq_oe, 1'b0);
    rst_n = 1'b1;
    rd_chk(2'b11, 20'h12345, 16'h773c, 1'b0);
    $display("t_reset done");
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      test_done();
    end
  end
  initial begin
    repeat (10) @(posedge core_clk);
    #1 rst_n = 1'b1;
    @(posedge core_clk);
    #1 t_full();
    t_lanes();
    t_err();
    t_freeze();
    t_reset();
    test_done();
  end
endmodule // async_sram_ecc_access_test
